// >>> roc_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ROC_MAP_SVH
`define ROC_MAP_SVH

// ==========================================================
// Register byte addresses
`define ROC_A_CTRL     8'h00
`define ROC_A_THR      8'h04
`define ROC_A_DLY      8'h08
`define ROC_A_VRATED   8'h0c
`define ROC_A_STATUS   8'h10
`define ROC_A_IRQ_ST   8'h14
`define ROC_A_IRQ_MASK 8'h18

// ==========================================================
// Field positions
`define ROC_CTRL_EN    0
`define ROC_CTRL_SO    1
`define ROC_ST_START   0
`define ROC_ST_TRIP    1
`define ROC_ST_FVALID  2
`define ROC_ST_VOK     3
`define ROC_EV_ST_ON   0
`define ROC_EV_ST_OFF  1
`define ROC_EV_TR_ON   2
`define ROC_EV_TR_OFF  3

// ==========================================================
// Settings in 0.01 Hz/s and ms
`define ROC_THR_RST    11'sh032
`define ROC_THR_MAX    16'sh01f4
`define ROC_THR_MIN    (-16'sh01f4)
`define ROC_RATIO_BRK  48'sh32
`define ROC_RATIO_HI   48'sh398
`define ROC_RATIO_LO   48'sh3e7
`define ROC_RATIO_DEN  48'sh3e8
`define ROC_SLOPE_SCL  48'sh64
`define ROC_DLY_RST    14'h00c8
`define ROC_DLY_MIN    16'h00c8
`define ROC_DLY_MAX    16'h2710
`define ROC_VRATED_RST 16'h2710
`define ROC_VMIN_PCT   32'h0000000a
`define ROC_PCT_FULL   32'h00000064

// ==========================================================
// Timing
`define ROC_CLK_NS     8
`define ROC_MS_NS      1000000
`define ROC_FILT_MS    100
`define ROC_FILT_CNT   7'h64
`define ROC_HIST_N     3'h5
`define ROC_QUAL_N     3'h4

`endif

// >>> roc_pkg.sv
// Types shared by the rate-of-change-of-frequency element
`default_nettype none
package roc_pkg;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} roc_bus_t;

	typedef struct packed {
		logic        stb;
		logic        valid;
		logic [16:0] mhz;
	} roc_freq_t;

	// ==========================================================
	// States
	typedef enum logic [2:0] {
		ROC_IDLE = 3'b001,
		ROC_FILT = 3'b010,
		ROC_ACT  = 3'b100
	} roc_fsm_t;

	typedef struct packed {
		logic [2:0] vcnt;
		logic [2:0] icnt;
		roc_freq_t  out;
	} roc_qual_st_t;

	typedef struct packed {
		logic [16:0] cnt;
		logic        tick;
	} roc_tick_st_t;

	typedef struct packed {
		logic               en;
		logic               so;
		logic signed [10:0] thr;
		logic [13:0]        dly;
		logic [15:0]        vrated;
		logic [3:0]         irq_st;
		logic [3:0]         irq_mask;
		logic [31:0]        rdata;
		roc_fsm_t           fsm;
		logic [6:0]         fcnt;
		logic [13:0]        dcnt;
		logic               start;
		logic               trip;
		logic [3:0]         ev;
		logic [15:0]        ms;
		logic [2:0]         ptr;
		logic [2:0]         fill;
		logic [4:0][16:0]   hf;
		logic [4:0][15:0]   ht;
		logic               sv;
		logic               pick;
		logic               drop;
	} roc_st_t;

endpackage : roc_pkg
`default_nettype wire

// >>> roc_ms_tick.sv
// Millisecond tick divider
`include "roc_map.svh"
`timescale 1ns/1ns
`default_nettype none
module roc_ms_tick #(
	parameter int unsigned TICK_CYC = `ROC_MS_NS / `ROC_CLK_NS
) (
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	output var logic  tick_o
);
	roc_pkg::roc_tick_st_t r;
	roc_pkg::roc_tick_st_t n;

	always_comb begin
		n      = r;
		n.tick = 1'b0;
		if (r.cnt == 17'(TICK_CYC - 1)) begin
			n.cnt  = '0;
			n.tick = 1'b1;
		end else begin
			n.cnt = r.cnt + 17'h00001;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign tick_o = r.tick;

	tick_period_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(r.tick) |-> $past(r.cnt) == 17'(TICK_CYC - 1))
		else $error("ms tick off period");

endmodule : roc_ms_tick
`default_nettype wire

// >>> roc_freq_qual.sv
// Frequency acceptance filter: four valid to accept, four invalid to clear
`include "roc_map.svh"
`timescale 1ns/1ns
`default_nettype none
module roc_freq_qual (
	input  wire logic               sys_clk_i,
	input  wire logic               rst_n_i,
	input  wire roc_pkg::roc_freq_t meas_i,
	output var roc_pkg::roc_freq_t  qual_o
);
	roc_pkg::roc_qual_st_t r;
	roc_pkg::roc_qual_st_t n;

	always_comb begin
		n         = r;
		n.out.stb = 1'b0;
		if (meas_i.stb) begin
			if (meas_i.valid) begin
				n.icnt = '0;
				n.vcnt = (r.vcnt == `ROC_QUAL_N) ? r.vcnt : r.vcnt + 3'h1;
				if (n.vcnt == `ROC_QUAL_N) begin
					n.out.valid = 1'b1;
					n.out.mhz   = meas_i.mhz;
					n.out.stb   = 1'b1;
				end
			end else begin
				n.vcnt = '0;
				n.icnt = (r.icnt == `ROC_QUAL_N) ? r.icnt : r.icnt + 3'h1;
				if (n.icnt == `ROC_QUAL_N) begin
					n.out.valid = 1'b0;
					n.out.mhz   = '0;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign qual_o = r.out;

	accept_four_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(r.out.valid) |-> r.vcnt == `ROC_QUAL_N && $past(meas_i.valid))
		else $error("frequency accepted too early");

	clear_four_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$fell(r.out.valid) |-> r.icnt == `ROC_QUAL_N && r.out.mhz == '0)
		else $error("frequency cleared too early");

endmodule : roc_freq_qual
`default_nettype wire

// >>> roc_protection.sv
// Rate-of-change-of-frequency protection element with register port
//
// Our own choices: the register offsets and the address-and-strobe port.
`include "roc_map.svh"
`timescale 1ns/1ns
`default_nettype none
module roc_protection #(
	parameter int unsigned MS_CYC = `ROC_MS_NS / `ROC_CLK_NS
) (
	input  wire logic               sys_clk_i,
	input  wire logic               rst_n_i,
	input  wire roc_pkg::roc_bus_t  bus_i,
	output var logic [31:0]         rdata_o,
	input  wire roc_pkg::roc_freq_t freq_i,
	input  wire logic [15:0]        volt_i,
	input  wire logic               block_input_i,
	output var logic                general_start_out_o,
	output var logic                general_trip_out_o,
	output var logic [3:0]          event_o,
	output var logic                irq_o
);
	// ==========================================================
	// Reset release
	logic               rst_meta;
	logic               rst_n;
	roc_pkg::roc_st_t   r;
	roc_pkg::roc_st_t   n;
	roc_pkg::roc_freq_t fq;
	logic               tick;
	logic               vok;
	logic               active;
	logic signed [15:0] wthr;
	logic [15:0]        wdly;
	logic signed [47:0] df;
	logic signed [47:0] num;
	logic signed [47:0] dts;
	logic signed [47:0] thr_s;
	logic signed [47:0] lim;
	logic signed [47:0] an;
	logic signed [47:0] at;
	logic signed [47:0] ratio;
	logic [3:0]         clr;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	roc_ms_tick #(.TICK_CYC(MS_CYC)) u_tick (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n),
		.tick_o    (tick)
	);

	roc_freq_qual u_qual (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n),
		.meas_i    (freq_i),
		.qual_o    (fq)
	);

	// Product form avoids a divider: volt/rated > 10 percent
	assign vok = 32'(volt_i) * `ROC_PCT_FULL > 32'(r.vrated) * `ROC_VMIN_PCT;
	assign active = r.en && !block_input_i && vok && fq.valid && r.sv;

	// ==========================================================
	// Slope against threshold, cross-multiplied by elapsed ms
	always_comb begin
		df    = 48'($signed({1'b0, fq.mhz})) - 48'($signed({1'b0, r.hf[r.ptr]}));
		num   = df * `ROC_SLOPE_SCL;
		// Gap taken at 16 bits so a wrapped ms counter still gives the true elapsed time
		dts   = 48'(16'(r.ms - r.ht[r.ptr]));
		thr_s = 48'(r.thr);
		lim   = thr_s * dts;
		an    = (num < 0) ? -num : num;
		at    = (thr_s < 0) ? -thr_s : thr_s;
		ratio = (at > `ROC_RATIO_BRK) ? `ROC_RATIO_HI : `ROC_RATIO_LO;
	end

	// ==========================================================
	// Next state
	always_comb begin
		n       = r;
		n.rdata = '0;
		n.ev    = '0;
		clr     = '0;
		wthr    = $signed(bus_i.wdata[15:0]);
		wdly    = bus_i.wdata[15:0];

		if (tick) begin
			n.ms = r.ms + 16'h0001;
		end

		// Register writes; out-of-range settings clamp to the limits
		if (bus_i.wr) begin
			unique case (bus_i.addr)
				`ROC_A_CTRL: begin
					n.en = bus_i.wdata[`ROC_CTRL_EN];
					n.so = bus_i.wdata[`ROC_CTRL_SO];
				end
				`ROC_A_THR: begin
					if (wthr > `ROC_THR_MAX) begin
						n.thr = 11'(`ROC_THR_MAX);
					end else if (wthr < `ROC_THR_MIN) begin
						n.thr = 11'(`ROC_THR_MIN);
					end else begin
						n.thr = 11'(wthr);
					end
				end
				`ROC_A_DLY: begin
					if (wdly > `ROC_DLY_MAX) begin
						n.dly = 14'(`ROC_DLY_MAX);
					end else if (wdly < `ROC_DLY_MIN) begin
						n.dly = 14'(`ROC_DLY_MIN);
					end else begin
						n.dly = 14'(wdly);
					end
				end
				`ROC_A_VRATED: n.vrated = bus_i.wdata[15:0];
				`ROC_A_IRQ_ST: clr = bus_i.wdata[3:0];
				`ROC_A_IRQ_MASK: n.irq_mask = bus_i.wdata[3:0];
				default: ;
			endcase
		end

		// Reads answer in the next cycle; unmapped reads give zero
		if (bus_i.rd) begin
			unique case (bus_i.addr)
				`ROC_A_CTRL: n.rdata = {30'h0, r.so, r.en};
				`ROC_A_THR: n.rdata = 32'(r.thr);
				`ROC_A_DLY: n.rdata = {18'h0, r.dly};
				`ROC_A_VRATED: n.rdata = {16'h0, r.vrated};
				`ROC_A_STATUS: n.rdata = {28'h0, vok, fq.valid, r.trip, r.start};
				`ROC_A_IRQ_ST: n.rdata = {28'h0, r.irq_st};
				`ROC_A_IRQ_MASK: n.rdata = {28'h0, r.irq_mask};
				default: n.rdata = '0;
			endcase
		end

		// Five-period history ring; the slot about to be reused is the old sample
		if (!fq.valid) begin
			n.fill = '0;
			n.sv   = 1'b0;
		end else if (fq.stb) begin
			n.hf[r.ptr] = fq.mhz;
			n.ht[r.ptr] = r.ms;
			n.ptr       = (r.ptr == `ROC_HIST_N - 3'h1) ? 3'h0 : r.ptr + 3'h1;
			n.fill      = (r.fill == `ROC_HIST_N) ? r.fill : r.fill + 3'h1;
			if (r.fill == `ROC_HIST_N) begin
				n.sv   = 1'b1;
				n.pick = (thr_s >= 0) ? (num > lim) : (num < lim);
				n.drop = an * `ROC_RATIO_DEN < ratio * at * dts;
			end
		end

		// Criterion, 100 ms filter, delay timer from onset
		unique case (r.fsm)
			roc_pkg::ROC_IDLE: begin
				n.fcnt = '0;
				n.dcnt = '0;
				if (active && r.pick) begin
					n.fsm = roc_pkg::ROC_FILT;
				end
			end
			roc_pkg::ROC_FILT: begin
				if (!active || r.drop) begin
					n.fsm = roc_pkg::ROC_IDLE;
					n.dcnt = '0;
				end else if (tick) begin
					n.fcnt = r.fcnt + 7'h01;
					n.dcnt = r.dcnt + 14'h0001;
					if (n.fcnt == `ROC_FILT_CNT) begin
						n.fsm = roc_pkg::ROC_ACT;
					end
				end
			end
			roc_pkg::ROC_ACT: begin
				if (!active || r.drop) begin
					n.fsm = roc_pkg::ROC_IDLE;
					n.dcnt = '0;
				end else if (tick && r.dcnt != 14'h3fff) begin
					n.dcnt = r.dcnt + 14'h0001;
				end
			end
			default: n.fsm = roc_pkg::ROC_IDLE;
		endcase

		n.start = (n.fsm == roc_pkg::ROC_ACT);
		n.trip  = n.start && !r.so && (n.dcnt >= r.dly);

		// Events: set wins over a same-cycle clear
		n.ev[`ROC_EV_ST_ON]  = n.start && !r.start;
		n.ev[`ROC_EV_ST_OFF] = !n.start && r.start;
		n.ev[`ROC_EV_TR_ON]  = n.trip && !r.trip;
		n.ev[`ROC_EV_TR_OFF] = !n.trip && r.trip;
		n.irq_st = (r.irq_st & ~clr) | n.ev;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			r        <= '0;
			r.fsm    <= roc_pkg::ROC_IDLE;
			r.thr    <= `ROC_THR_RST;
			r.dly    <= `ROC_DLY_RST;
			r.vrated <= `ROC_VRATED_RST;
		end else begin
			r <= n;
		end
	end

	// ==========================================================
	// Outputs
	assign rdata_o             = r.rdata;
	assign general_start_out_o = r.start;
	assign general_trip_out_o  = r.trip;
	assign event_o             = r.ev;
	assign irq_o               = |(r.irq_st & r.irq_mask);

	// ==========================================================
	// Checks
	off_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		!r.en |=> !r.start && !r.trip)
		else $error("output while disabled");

	start_only_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		r.so |=> !r.trip)
		else $error("trip while start only");

	thr_range_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		r.thr >= 11'(`ROC_THR_MIN) && r.thr <= 11'(`ROC_THR_MAX))
		else $error("threshold out of range");

	dly_range_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		r.dly >= 14'(`ROC_DLY_MIN) && r.dly <= 14'(`ROC_DLY_MAX))
		else $error("delay out of range");

	block_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		block_input_i |=> !r.start && !r.trip)
		else $error("output while blocked");

	trip_time_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		$rose(r.trip) |-> r.start && r.dcnt == r.dly && r.dcnt > 14'(`ROC_FILT_CNT))
		else $error("trip at wrong delay");

	filt_done_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		$rose(r.start) |-> r.fcnt == `ROC_FILT_CNT && $past(r.fsm) == roc_pkg::ROC_FILT)
		else $error("start before filter time");

	trip_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		$fell(r.start) |-> !r.trip && r.dcnt == '0)
		else $error("timer kept after drop");

	event_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		$changed(r.trip) |-> r.irq_st[`ROC_EV_TR_ON] || r.irq_st[`ROC_EV_TR_OFF])
		else $error("trip edge without event");

	start_on_ev_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		$rose(r.start) |-> r.ev[`ROC_EV_ST_ON] && r.irq_st[`ROC_EV_ST_ON])
		else $error("start rise without event");

	start_off_ev_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		$fell(r.start) |-> r.ev[`ROC_EV_ST_OFF] && r.irq_st[`ROC_EV_ST_OFF])
		else $error("start fall without event");

	irq_sticky_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		$fell(r.irq_st[`ROC_EV_TR_ON]) |-> $past(bus_i.wr) && $past(bus_i.addr) == `ROC_A_IRQ_ST)
		else $error("event flag lost without clear");

	vok_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		!vok || !fq.valid |=> !r.start && !r.trip)
		else $error("output without voltage or frequency");

	pick_entry_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		r.fsm == roc_pkg::ROC_FILT && $past(r.fsm) == roc_pkg::ROC_IDLE |-> $past(r.pick))
		else $error("filter entered without pick");

	drop_exit_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		r.fsm == roc_pkg::ROC_ACT && r.drop |=> r.fsm == roc_pkg::ROC_IDLE)
		else $error("start kept after drop-off");

endmodule : roc_protection
`default_nettype wire

// >>> roc_freq_src.sv
// Frequency measurement stand-in: one result per period with a set ramp
`timescale 1ns/1ns
`default_nettype none
module roc_freq_src #(
	parameter int unsigned PER_CYC = 400
) (
	input  wire logic               sys_clk_i,
	input  wire logic               rst_n_i,
	input  wire logic               valid_i,
	input  wire logic signed [15:0] step_i,
	output var roc_pkg::roc_freq_t  freq_o
);
	int unsigned cnt_reg;
	logic [16:0] f_reg;

	// ==========================================================
	// One result per period, so five results span five periods
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= 0;
			f_reg <= 17'h0c350;
			freq_o <= '0;
		end else begin
			cnt_reg <= (cnt_reg == PER_CYC - 1) ? 0 : cnt_reg + 1;
			freq_o.stb <= (cnt_reg == PER_CYC - 1);
			if (cnt_reg == PER_CYC - 1) begin
				f_reg <= f_reg + 17'(step_i);
				freq_o.valid <= valid_i;
				freq_o.mhz <= f_reg + 17'(step_i);
			end else begin
				// Not held between results, so stale reuse shows up
				freq_o.valid <= ~freq_o.valid;
				freq_o.mhz <= ~freq_o.mhz;
			end
		end
	end
endmodule : roc_freq_src
`default_nettype wire

// >>> test_rocof_protection.sv
// Self-checking bench for the rate-of-change-of-frequency element
`include "roc_map.svh"
`timescale 1ns/1ns
`default_nettype none
module test_rocof_protection;
	// Short millisecond keeps the 100 ms filter and 200 ms delay cheap
	localparam int unsigned MS = 20;
	typedef struct packed {
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic [31:0] exp;
	} roc_row_t;

	logic               sys_clk_i;
	logic               rst_n_i;
	roc_pkg::roc_bus_t  bus;
	roc_pkg::roc_freq_t freq;
	logic [31:0]        rdata;
	logic [15:0]        volt;
	logic               blk;
	logic               start;
	logic               trip;
	logic [3:0]         ev;
	logic               irq;
	logic               valid;
	logic signed [15:0] step;
	int                 err_count;
	int                 samples_checked;
	int                 n;
	roc_row_t           rows [14];

	roc_freq_src #(.PER_CYC(20 * MS)) roc_freq_src_inst (
		.sys_clk_i(sys_clk_i),
		.rst_n_i  (rst_n_i),
		.valid_i  (valid),
		.step_i   (step),
		.freq_o   (freq)
	);

	roc_protection #(.MS_CYC(MS)) roc_protection_inst (
		.sys_clk_i          (sys_clk_i),
		.rst_n_i            (rst_n_i),
		.bus_i              (bus),
		.rdata_o            (rdata),
		.freq_i             (freq),
		.volt_i             (volt),
		.block_input_i      (blk),
		.general_start_out_o(start),
		.general_trip_out_o (trip),
		.event_o            (ev),
		.irq_o              (irq)
	);

	// ==========================================================
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		if (err_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		bus <= '{1'b1, 1'b0, a, d};
		@(posedge sys_clk_i);
		bus <= '0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk_i);
		bus <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge sys_clk_i);
		bus <= '0;
		#1;
		d = rdata;
	endtask : rd_reg

	task automatic wait_for(input int sel, input logic lvl, input int lim);
		n = 0;
		while ((sel ? trip : start) !== lvl && n < lim) begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end
		if (n >= lim) begin
			err_count++;
			end_sim();
		end
	endtask : wait_for

	task automatic wait_stb(input int k);
		repeat (k) begin
			@(posedge sys_clk_i);
			#1;
			for (int j = 0; j < 500 && freq.stb !== 1'b1; j++) begin
				@(posedge sys_clk_i);
				#1;
			end
			if (freq.stb !== 1'b1) begin
				err_count++;
				end_sim();
			end
		end
	endtask : wait_stb

	// ==========================================================
	// Stimulus
	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end

	initial begin
		repeat (100000) @(posedge sys_clk_i);
		err_count++;
		end_sim();
	end

	initial begin
		logic [31:0] d;
		rst_n_i = 1'b0;
		bus = '0;
		volt = 16'h2710;
		blk = 1'b0;
		valid = 1'b1;
		step = 16'sh0014;
		err_count = 0;
		samples_checked = 0;
		rows = '{
			'{1'b0, `ROC_A_CTRL, 32'h0, 32'h0}, '{1'b0, `ROC_A_THR, 32'h0, 32'h32},
			'{1'b0, `ROC_A_DLY, 32'h0, 32'hc8}, '{1'b0, `ROC_A_VRATED, 32'h0, 32'h2710},
			'{1'b0, `ROC_A_IRQ_MASK, 32'h0, 32'h0}, '{1'b0, `ROC_A_IRQ_ST, 32'h0, 32'h0},
			'{1'b1, 8'h1c, 32'hffffffff, 32'h0}, '{1'b1, `ROC_A_STATUS, 32'hf, 32'h8},
			'{1'b1, `ROC_A_THR, 32'h7fff, 32'h1f4}, '{1'b1, `ROC_A_THR, 32'hfda8, 32'hfffffe0c},
			'{1'b1, `ROC_A_DLY, 32'h32, 32'hc8}, '{1'b1, `ROC_A_DLY, 32'h4e20, 32'h2710},
			'{1'b1, `ROC_A_THR, 32'h32, 32'h32}, '{1'b1, `ROC_A_DLY, 32'hc8, 32'hc8}};
		repeat (10) @(posedge sys_clk_i);
		check({25'h0, start, trip, irq, ev}, 32'h0);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		for (int i = 0; i < 14; i++) begin
			if (rows[i].wr) begin
				wr_reg(rows[i].addr, rows[i].wdata);
			end
			rd_reg(rows[i].addr, d);
			check(d, rows[i].exp);
		end
		// Rising ramp of 1 Hz/s with the element still off
		repeat (6000) @(posedge sys_clk_i);
		#1;
		check({31'h0, start}, 32'h0);
		rd_reg(`ROC_A_STATUS, d);
		check(d, 32'hc);
		wr_reg(`ROC_A_IRQ_MASK, 32'hf);
		wr_reg(`ROC_A_CTRL, 32'h1);
		wait_for(0, 1'b1, 4000);
		check({27'h0, irq, ev}, 32'h11);
		wait_for(1, 1'b1, 3000);
		check(32'(n >= (`ROC_DLY_MIN - `ROC_FILT_MS - 1) * MS
			&& n <= (`ROC_DLY_MIN - `ROC_FILT_MS + 1) * MS), 32'h1);
		check({28'h0, ev}, 32'h4);
		// Exactly at threshold holds inside the band, just below drops
		@(posedge sys_clk_i);
		step <= 16'sh000a;
		repeat (1200) @(posedge sys_clk_i);
		#1;
		check({31'h0, start}, 32'h1);
		@(posedge sys_clk_i);
		step <= 16'sh0009;
		wait_for(0, 1'b0, 1200);
		check({27'h0, trip, ev}, 32'ha);
		rd_reg(`ROC_A_IRQ_ST, d);
		check(d, 32'hf);
		wr_reg(`ROC_A_IRQ_ST, 32'hf);
		rd_reg(`ROC_A_IRQ_ST, d);
		check({27'h0, irq, d[3:0]}, 32'h0);
		// Negative threshold picks up on a falling slope
		wr_reg(`ROC_A_THR, 32'hffce);
		@(posedge sys_clk_i);
		step <= 16'shffec;
		wait_for(0, 1'b1, 6000);
		check({28'h0, ev}, 32'h1);
		wr_reg(`ROC_A_THR, 32'h32);
		@(posedge sys_clk_i);
		step <= 16'sh0014;
		wait_for(0, 1'b0, 2000);
		check({27'h0, trip, ev}, 32'h2);
		@(posedge sys_clk_i);
		step <= 16'sh0014;
		wait_for(0, 1'b1, 4000);
		@(posedge sys_clk_i);
		blk <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		#1;
		check({30'h0, start, trip}, 32'h0);
		wr_reg(`ROC_A_CTRL, 32'h3);
		@(posedge sys_clk_i);
		blk <= 1'b0;
		wait_for(0, 1'b1, 4000);
		n = 0;
		repeat (3000) begin
			@(posedge sys_clk_i);
			#1;
			n += trip;
		end
		check(n, 32'h0);
		// Voltage exactly at ten percent of rated is not enough
		@(posedge sys_clk_i);
		volt <= 16'h03e8;
		wait_for(0, 1'b0, 1200);
		check({28'h0, ev}, 32'h2);
		wait_stb(1);
		@(posedge sys_clk_i);
		valid <= 1'b0;
		wait_stb(3);
		rd_reg(`ROC_A_STATUS, d);
		check(d, 32'h4);
		wait_stb(1);
		repeat (5) @(posedge sys_clk_i);
		rd_reg(`ROC_A_STATUS, d);
		check(d, 32'h0);
		end_sim();
	end
endmodule : test_rocof_protection
`default_nettype wire
